// ===== hw/esc_pkg.sv
// Package for the DMA event channel selector: register map, field layout, selector codes
package esc_pkg;
  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [31:0] addr_event_select_ch0_3   = 32'h01a0ff00;
  localparam logic [31:0] addr_event_select_ch4_7   = 32'h01a0ff04;
  localparam logic [31:0] addr_unused_gap           = 32'h01a0ff08;
  localparam logic [31:0] addr_event_select_ch12_15 = 32'h01a0ff0c;
  // ==========================================================================
  // Field layout
  localparam int field_width  = 6;
  localparam int field_stride = 8;
  localparam int num_channels = 16;
  localparam int num_mappable = 12;
  localparam int num_events   = 13;
  localparam int first_chain  = 8;
  localparam int last_chain   = 11;
  localparam logic [31:0] field_mask = 32'h3f3f3f3f;
  // ==========================================================================
  // Reset values: identity mapping
  localparam logic [31:0] reset_event_select_ch0_3   = 32'h03020100;
  localparam logic [31:0] reset_event_select_ch4_7   = 32'h07060504;
  localparam logic [31:0] reset_event_select_ch12_15 = 32'h0f0e0d0c;
  // ==========================================================================
  // Selector codes
  localparam logic [5:0] code_host_port     = 6'h00;
  localparam logic [5:0] code_timer0        = 6'h01;
  localparam logic [5:0] code_timer1        = 6'h02;
  localparam logic [5:0] code_refresh_timer = 6'h03;
  localparam logic [5:0] code_gp_pin4       = 6'h04;
  localparam logic [5:0] code_gp_pin5       = 6'h05;
  localparam logic [5:0] code_gp_pin6       = 6'h06;
  localparam logic [5:0] code_gp_pin7       = 6'h07;
  localparam logic [5:0] code_gp_pin2       = 6'h0a;
  localparam logic [5:0] code_serial0_tx    = 6'h0c;
  localparam logic [5:0] code_serial0_rx    = 6'h0d;
  localparam logic [5:0] code_serial1_tx    = 6'h0e;
  localparam logic [5:0] code_serial1_rx    = 6'h0f;

  // Event sources in one carrier
  typedef struct packed {
    logic host_port_event;
    logic timer0_event;
    logic timer1_event;
    logic refresh_timer_event;
    logic gp_pin4_event;
    logic gp_pin5_event;
    logic gp_pin6_event;
    logic gp_pin7_event;
    logic gp_pin2_event;
    logic serial0_tx_event;
    logic serial0_rx_event;
    logic serial1_tx_event;
    logic serial1_rx_event;
  } esc_events_type;

  // APB request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } esc_apb_req_type;
endpackage

// ===== hw/esc_selector.sv
// DMA event channel selector: APB registers and event-to-channel routing
// Function
// - Sixteen DMA channel trigger outputs, each driven by one event.
// - Channels 8 to 11 follow chaining codes only; twelve channels remap.
// - Selector registers decode at 0x01A0FF00, 0x01A0FF04 and 0x01A0FF0C.
// - Each mappable channel has a 6-bit code choosing its event.
// - Fields at bits 5:0, 13:8, 21:16, 29:24 in channel order.
// - Reset loads identity mapping: code equals channel number.
// - Codes map to host port, timers, refresh, gp pins, serial ports.
// - Two-bit gaps between fields are read-only zero.
// - Code fields are read/write; writes change routing immediately after.
// - Gp pin events come from the gpio block, not raw pins.
//
// Register access over APB was left to the implementer.
module esc_selector (
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire esc_pkg::esc_apb_req_type apb_req,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire esc_pkg::esc_events_type  events,
  input  wire logic [3:0]               chain_code_in,
  output logic [15:0]                   channel_trigger
);
  // ==========================================================================
  // Register storage
  logic [31:0] event_select_ch0_3;
  logic [31:0] event_select_ch4_7;
  logic [31:0] event_select_ch12_15;

  // ==========================================================================
  // APB decode; zero wait states, every access answered in its access cycle
  wire logic access    = apb_req.psel & apb_req.penable;
  wire logic wr        = access & apb_req.pwrite;
  wire logic hit_0_3   = (apb_req.paddr == esc_pkg::addr_event_select_ch0_3);
  wire logic hit_4_7   = (apb_req.paddr == esc_pkg::addr_event_select_ch4_7);
  wire logic hit_12_15 = (apb_req.paddr == esc_pkg::addr_event_select_ch12_15);
  // Gap kept masked to zero; writes fall through unnoticed
  wire logic [31:0] wdata_masked = apb_req.pwdata & esc_pkg::field_mask;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      event_select_ch0_3   <= esc_pkg::reset_event_select_ch0_3;
      event_select_ch4_7   <= esc_pkg::reset_event_select_ch4_7;
      event_select_ch12_15 <= esc_pkg::reset_event_select_ch12_15;
    end else begin
      if (wr && hit_0_3)   event_select_ch0_3   <= wdata_masked;
      if (wr && hit_4_7)   event_select_ch4_7   <= wdata_masked;
      if (wr && hit_12_15) event_select_ch12_15 <= wdata_masked;
    end
  end

  // Read data registered during setup so it is stable through the access phase
  wire logic setup = apb_req.psel & ~apb_req.penable;
  wire logic [31:0] next_prdata =
    hit_0_3   ? event_select_ch0_3 :
    hit_4_7   ? event_select_ch4_7 :
    hit_12_15 ? event_select_ch12_15 : 32'h00000000;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= next_prdata;
    end
  end

  // ==========================================================================
  // Routing
  function automatic logic pick_event(input logic [5:0] code,
                                      input esc_pkg::esc_events_type ev);
    logic r;
    r = 1'b0;
    unique case (code)
      esc_pkg::code_host_port:     r = ev.host_port_event;
      esc_pkg::code_timer0:        r = ev.timer0_event;
      esc_pkg::code_timer1:        r = ev.timer1_event;
      esc_pkg::code_refresh_timer: r = ev.refresh_timer_event;
      esc_pkg::code_gp_pin4:       r = ev.gp_pin4_event;
      esc_pkg::code_gp_pin5:       r = ev.gp_pin5_event;
      esc_pkg::code_gp_pin6:       r = ev.gp_pin6_event;
      esc_pkg::code_gp_pin7:       r = ev.gp_pin7_event;
      esc_pkg::code_gp_pin2:       r = ev.gp_pin2_event;
      esc_pkg::code_serial0_tx:    r = ev.serial0_tx_event;
      esc_pkg::code_serial0_rx:    r = ev.serial0_rx_event;
      esc_pkg::code_serial1_tx:    r = ev.serial1_tx_event;
      esc_pkg::code_serial1_rx:    r = ev.serial1_rx_event;
      default:                     r = 1'b0;
    endcase
    return r;
  endfunction

  // Field of a mappable channel; chaining channels never read this
  function automatic logic [5:0] field_of(input int ch,
                                          input logic [31:0] r0,
                                          input logic [31:0] r1,
                                          input logic [31:0] r3);
    logic [31:0] reg_sel;
    int          lane;
    reg_sel = (ch < 4) ? r0 : ((ch < 8) ? r1 : r3);
    lane    = ch % 4;
    return reg_sel[lane*esc_pkg::field_stride +: esc_pkg::field_width];
  endfunction

  // Events arrive from logic on this clock (gpio already edge-detected), so
  // no synchroniser; output registered to give a clean one-cycle trigger.
  logic [15:0] next_trigger;
  always_comb begin
    next_trigger = 16'h0000;
    for (int ch = 0; ch < esc_pkg::num_channels; ch++) begin
      if (ch < esc_pkg::first_chain || ch > esc_pkg::last_chain) begin
        next_trigger[ch] = pick_event(field_of(ch, event_select_ch0_3,
                                               event_select_ch4_7,
                                               event_select_ch12_15), events);
      end
    end
    // Chaining channels own no field, so no register write can steal them
    next_trigger[esc_pkg::last_chain:esc_pkg::first_chain] = chain_code_in;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      channel_trigger <= 16'h0000;
    end else begin
      channel_trigger <= next_trigger;
    end
  end

  // ==========================================================================
  // Assertions
  property p_gap_zero;
    @(posedge clk) disable iff (!rst_b)
      ((event_select_ch0_3 | event_select_ch4_7 | event_select_ch12_15)
        & ~esc_pkg::field_mask) == 32'h00000000;
  endproperty
  a_gap_zero: assert property (p_gap_zero) else $error("gap bits set");

  property p_write_lands;
    @(posedge clk) disable iff (!rst_b)
      (wr && hit_4_7) |=> (event_select_ch4_7 == $past(wdata_masked));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write lost");

  property p_gap_write_ignored;
    @(posedge clk) disable iff (!rst_b)
      (wr && apb_req.paddr == esc_pkg::addr_unused_gap) |=>
        $stable(event_select_ch0_3) && $stable(event_select_ch4_7) &&
        $stable(event_select_ch12_15);
  endproperty
  a_gap_write_ignored: assert property (p_gap_write_ignored) else $error("gap write");

  property p_chain_route;
    @(posedge clk) disable iff (!rst_b)
      ##1 channel_trigger[11:8] == $past(chain_code_in);
  endproperty
  a_chain_route: assert property (p_chain_route) else $error("chain route");

  property p_ch15_timer0;
    @(posedge clk) disable iff (!rst_b)
      (event_select_ch12_15[29:24] == esc_pkg::code_timer0) |=>
        channel_trigger[15] == $past(events.timer0_event);
  endproperty
  a_ch15_timer0: assert property (p_ch15_timer0) else $error("ch15 route");

  property p_reserved_silent;
    @(posedge clk) disable iff (!rst_b)
      (event_select_ch0_3[5:0] >= 6'h10 || event_select_ch0_3[5:0] == 6'h08) |=>
        !channel_trigger[0];
  endproperty
  a_reserved_silent: assert property (p_reserved_silent) else $error("reserved");

  property p_ch4_gp;
    @(posedge clk) disable iff (!rst_b)
      (event_select_ch4_7[5:0] == esc_pkg::code_gp_pin4) |=>
        channel_trigger[4] == $past(events.gp_pin4_event);
  endproperty
  a_ch4_gp: assert property (p_ch4_gp) else $error("ch4 route");

  property p_read_data;
    @(posedge clk) disable iff (!rst_b)
      (setup && hit_12_15 && !wr) |=> prdata == $past(event_select_ch12_15);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data");

  property p_reset_identity;
    @(posedge clk) !rst_b |=> event_select_ch4_7 == esc_pkg::reset_event_select_ch4_7;
  endproperty
  a_reset_identity: assert property (p_reset_identity) else $error("reset map");

  // ==========================================================================
  // Register map assertions
  property p_reset_identity_0_3;
    @(posedge clk) !rst_b |=> event_select_ch0_3 == esc_pkg::reset_event_select_ch0_3;
  endproperty
  a_reset_identity_0_3: assert property (p_reset_identity_0_3) else $error("reset");

  property p_reset_identity_12_15;
    @(posedge clk) !rst_b |=>
      event_select_ch12_15 == esc_pkg::reset_event_select_ch12_15;
  endproperty
  a_reset_identity_12_15: assert property (p_reset_identity_12_15) else $error("reset");

  property p_reset_quiet;
    @(posedge clk) !rst_b |=>
      channel_trigger == 16'h0000 && prdata == 32'h00000000;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("reset outputs");

  property p_write_lands_0_3;
    @(posedge clk) disable iff (!rst_b)
      (wr && hit_0_3) |=> (event_select_ch0_3 == $past(wdata_masked));
  endproperty
  a_write_lands_0_3: assert property (p_write_lands_0_3) else $error("write lost");

  property p_write_lands_12_15;
    @(posedge clk) disable iff (!rst_b)
      (wr && hit_12_15) |=> (event_select_ch12_15 == $past(wdata_masked));
  endproperty
  a_write_lands_12_15: assert property (p_write_lands_12_15) else $error("write lost");

  property p_decode_exclusive;
    @(posedge clk) disable iff (!rst_b)
      (wr && hit_0_3) |=>
        $stable(event_select_ch4_7) && $stable(event_select_ch12_15);
  endproperty
  a_decode_exclusive: assert property (p_decode_exclusive) else $error("decode");

  property p_read_data_0_3;
    @(posedge clk) disable iff (!rst_b)
      (setup && hit_0_3) |=> prdata == $past(event_select_ch0_3);
  endproperty
  a_read_data_0_3: assert property (p_read_data_0_3) else $error("read data");

  property p_read_data_4_7;
    @(posedge clk) disable iff (!rst_b)
      (setup && hit_4_7) |=> prdata == $past(event_select_ch4_7);
  endproperty
  a_read_data_4_7: assert property (p_read_data_4_7) else $error("read data");

  property p_gap_read_zero;
    @(posedge clk) disable iff (!rst_b)
      (setup && !hit_0_3 && !hit_4_7 && !hit_12_15) |=> prdata == 32'h00000000;
  endproperty
  a_gap_read_zero: assert property (p_gap_read_zero) else $error("gap read");

  property p_read_gap_zero;
    @(posedge clk) disable iff (!rst_b)
      (prdata & ~esc_pkg::field_mask) == 32'h00000000;
  endproperty
  a_read_gap_zero: assert property (p_read_gap_zero) else $error("read gap bits");

  // ==========================================================================
  // Routing assertions
  property p_idle_no_trigger;
    @(posedge clk) disable iff (!rst_b)
      (events == '0 && chain_code_in == 4'h0) |=> channel_trigger == 16'h0000;
  endproperty
  a_idle_no_trigger: assert property (p_idle_no_trigger) else $error("stray trigger");

  property p_ch0_host;
    @(posedge clk) disable iff (!rst_b)
      (event_select_ch0_3[5:0] == esc_pkg::code_host_port) |=>
        channel_trigger[0] == $past(events.host_port_event);
  endproperty
  a_ch0_host: assert property (p_ch0_host) else $error("ch0 route");

  property p_ch6_host;
    @(posedge clk) disable iff (!rst_b)
      (event_select_ch4_7[21:16] == esc_pkg::code_host_port) |=>
        channel_trigger[6] == $past(events.host_port_event);
  endproperty
  a_ch6_host: assert property (p_ch6_host) else $error("ch6 route");

  property p_ch7_gp2;
    @(posedge clk) disable iff (!rst_b)
      (event_select_ch4_7[29:24] == esc_pkg::code_gp_pin2) |=>
        channel_trigger[7] == $past(events.gp_pin2_event);
  endproperty
  a_ch7_gp2: assert property (p_ch7_gp2) else $error("ch7 route");

  property p_ch12_serial;
    @(posedge clk) disable iff (!rst_b)
      (event_select_ch12_15[5:0] == esc_pkg::code_serial0_tx) |=>
        channel_trigger[12] == $past(events.serial0_tx_event);
  endproperty
  a_ch12_serial: assert property (p_ch12_serial) else $error("ch12 route");

  property p_reserved_ch1;
    @(posedge clk) disable iff (!rst_b)
      (event_select_ch0_3[13:8] == 6'h09 || event_select_ch0_3[13:8] == 6'h0b) |=>
        !channel_trigger[1];
  endproperty
  a_reserved_ch1: assert property (p_reserved_ch1) else $error("reserved");

  c_write: cover property (@(posedge clk) disable iff (!rst_b) wr && hit_0_3);
  c_gap_read: cover property (@(posedge clk) disable iff (!rst_b)
    access && apb_req.paddr == esc_pkg::addr_unused_gap);
  c_trigger: cover property (@(posedge clk) disable iff (!rst_b) channel_trigger[12]);
  c_remap_timer0: cover property (@(posedge clk) disable iff (!rst_b)
    event_select_ch12_15[29:24] == esc_pkg::code_timer0 && channel_trigger[15]);
  c_reserved: cover property (@(posedge clk) disable iff (!rst_b)
    event_select_ch0_3[5:0] == 6'h08);
endmodule

// ===== testbench/esc_dma_model.sv
// Behavioural model of the DMA controller's channel trigger inputs
module esc_dma_model (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [15:0] channel_trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  int hits [16];
  // ==========================================================================
  // Trigger counting
  // Each channel starts on its own single trigger line, one count per cycle high
  always @(posedge clk) begin
    for (int n = 0; n < 16; n++) begin
      if (!rst_b)
        hits[n] <= 0;
      else if (channel_trigger[n] === 1'b1)
        hits[n] <= hits[n] + 1;
    end
  end
endmodule

// ===== testbench/testbench.sv
// Self-checking testbench for the DMA event channel selector
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk = 1'b0;
  logic                     rst_b = 1'b0;
  esc_pkg::esc_apb_req_type req = '0;
  esc_pkg::esc_events_type  events = '0;
  logic [3:0]               chain = 4'h0;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic [15:0]              trig;
  int                       miscompares = 0;
  int                       checks = 0;
  always #5 clk = ~clk;
  esc_selector uut (.clk(clk), .rst_b(rst_b), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events), .chain_code_in(chain),
    .channel_trigger(trig));
  esc_dma_model dma (.clk(clk), .rst_b(rst_b), .channel_trigger(trig));
  // ==========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held until pready is seen high at a rising edge, released only then
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata);
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= addr;
    req.pwdata <= wdata;
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  // One-cycle event pulse; trigger output lags its cause by one cycle
  task automatic pulse(input logic [12:0] ev, input logic [3:0] cc, input logic [15:0] exp);
    @(posedge clk);
    events <= ev;
    chain <= cc;
    @(posedge clk);
    events <= '0;
    chain <= 4'h0;
    #1;
    check("channel_trigger", {16'h0, exp}, {16'h0, trig});
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic test_reset_map;
    logic [31:0] d;
    apb(1'b0, esc_pkg::addr_event_select_ch0_3, 32'h0, d);
    check("event_select_ch0_3", 32'h03020100, d);
    apb(1'b0, esc_pkg::addr_event_select_ch4_7, 32'h0, d);
    check("event_select_ch4_7", 32'h07060504, d);
    apb(1'b0, esc_pkg::addr_event_select_ch12_15, 32'h0, d);
    check("event_select_ch12_15", 32'h0f0e0d0c, d);
  endtask
  task automatic test_identity;
    logic [15:0] exp [13] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020,
      16'h0040, 16'h0080, 16'h0000, 16'h1000, 16'h2000, 16'h4000, 16'h8000};
    // Gp pin events arrive already edge-detected, as single-cycle pulses
    for (int i = 0; i < 13; i++) pulse(13'h1000 >> i, 4'h0, exp[i]);
  endtask
  task automatic test_remap;
    logic [31:0] d;
    apb(1'b1, esc_pkg::addr_event_select_ch12_15, 32'hcacacaca, d);
    apb(1'b0, esc_pkg::addr_event_select_ch12_15, 32'h0, d);
    check("event_select_ch12_15", 32'h0a0a0a0a, d);
    pulse(13'h0010, 4'h0, 16'hf000);
    pulse(13'h0008, 4'h0, 16'h0000);
  endtask
  task automatic test_reserved_gap;
    logic [31:0] d;
    apb(1'b1, esc_pkg::addr_event_select_ch0_3, 32'h3f100b08, d);
    pulse(13'h1fff, 4'h0, 16'hf0f0);
    apb(1'b1, esc_pkg::addr_unused_gap, 32'hffffffff, d);
    apb(1'b0, esc_pkg::addr_unused_gap, 32'h0, d);
    check("unused_gap", 32'h0, d);
    check("pslverr", 32'h0, {31'h0, pslverr});
    check("pready", 32'h1, {31'h0, pready});
    apb(1'b0, esc_pkg::addr_event_select_ch4_7, 32'h0, d);
    check("event_select_ch4_7", 32'h07060504, d);
    apb(1'b0, esc_pkg::addr_event_select_ch0_3, 32'h0, d);
    check("event_select_ch0_3", 32'h3f100b08, d);
  endtask
  task automatic test_chain;
    for (int i = 0; i < 4; i++) pulse(13'h0, 4'h1 << i, 16'h0100 << i);
    pulse(13'h1fff, 4'hf, 16'hfff0);
    // The model counts a trigger at the edge after it stands
    @(posedge clk);
    #1;
    check("hits_ch8", 32'h2, dma.hits[8]);
  endtask
  task automatic test_cross_map;
    logic [31:0] d;
    apb(1'b1, esc_pkg::addr_event_select_ch12_15, 32'h010f0e0d, d);
    apb(1'b1, esc_pkg::addr_event_select_ch4_7, 32'h0a000302, d);
    apb(1'b0, esc_pkg::addr_event_select_ch4_7, 32'h0, d);
    check("event_select_ch4_7", 32'h0a000302, d);
    pulse(13'h0800, 4'h0, 16'h8000);
    pulse(13'h0400, 4'h0, 16'h0010);
    pulse(13'h1214, 4'h0, 16'h10e0);
  endtask
  // Reset again after remapping: every field must fall back to identity
  task automatic test_mid_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check("channel_trigger", 32'h0, {16'h0, trig});
    test_reset_map();
    pulse(13'h0001, 4'h0, 16'h8000);
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    test_reset_map();
    test_identity();
    test_remap();
    test_reserved_gap();
    test_chain();
    test_cross_map();
    test_mid_reset();
    wrap_up();
  end
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule
